//--- rtl/lpc_regs.svh
`ifndef LPC_REGS_SVH
`define LPC_REGS_SVH
// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define LPC_IDX_LED_CONTROL   8'h18
`define LPC_IDX_PHY_CONTROL   8'h19
`define LPC_ADDR_LED_CONTROL  10'h060
`define LPC_ADDR_PHY_CONTROL  10'h064
`define LPC_LED_RESET         16'h0400
`define LPC_PHY_RESET         16'h8000
// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define LPC_LED_RATE_HI       10
`define LPC_LED_RATE_LO       9
`define LPC_LED_RATE_RESET    2'h2
`define LPC_LED_POL_BIT       7
`define LPC_LED_FORCE_BIT     4
`define LPC_LED_LEVEL_BIT     1
`define LPC_LED_RW_MASK       16'h0692
`define LPC_PHY_AUTOX_BIT     15
`define LPC_PHY_FORCEX_BIT    14
`define LPC_PHY_PRX_BIT       13
`define LPC_PHY_PTX_BIT       12
`define LPC_PHY_LINK_BIT      11
`define LPC_PHY_BYPASS_BIT    7
`define LPC_PHY_CFG_BIT       5
`define LPC_PHY_RW_MASK       16'hC0A0
// ------------------------------------------------------------
// Blink half periods
// ------------------------------------------------------------
`define LPC_CLK_HZ            50000000
`define LPC_BLINK_MS_0        50
`define LPC_BLINK_MS_1        100
`define LPC_BLINK_MS_2        200
`define LPC_BLINK_MS_3        500
`define LPC_MS_TO_CYC(ms)     ((ms) * (`LPC_CLK_HZ / 1000))
`endif

//--- rtl/lpc_pkg.sv
package lpc_pkg;
  typedef enum logic [1:0] {
    LPC_RATE_20HZ,
    LPC_RATE_10HZ,
    LPC_RATE_5HZ,
    LPC_RATE_2HZ
  } lpc_rate_t;
endpackage

//--- rtl/lpc_blinker.sv
`timescale 1ns/1ps
`include "lpc_regs.svh"
module lpc_blinker
  import lpc_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire lpc_rate_t rate_i,
  output logic           blink_o
);
  localparam logic [24:0] HALF_0 = 25'(`LPC_MS_TO_CYC(`LPC_BLINK_MS_0));
  localparam logic [24:0] HALF_1 = 25'(`LPC_MS_TO_CYC(`LPC_BLINK_MS_1));
  localparam logic [24:0] HALF_2 = 25'(`LPC_MS_TO_CYC(`LPC_BLINK_MS_2));
  localparam logic [24:0] HALF_3 = 25'(`LPC_MS_TO_CYC(`LPC_BLINK_MS_3));

  logic [24:0] cnt;
  logic [24:0] next_cnt;
  logic        next_blink;
  logic [24:0] limit;

  always_comb begin
    unique case (rate_i)
      LPC_RATE_20HZ: limit = HALF_0;
      LPC_RATE_10HZ: limit = HALF_1;
      LPC_RATE_5HZ:  limit = HALF_2;
      LPC_RATE_2HZ:  limit = HALF_3;
    endcase
    next_cnt   = cnt + 25'h000_0001;
    next_blink = blink_o;
    // Comparing with >= lets a slower-to-faster rate change end the phase at once.
    if (next_cnt >= limit) begin
      next_cnt   = 25'h000_0000;
      next_blink = ~blink_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt     <= 25'h000_0000;
      blink_o <= 1'b0;
    end else begin
      cnt     <= next_cnt;
      blink_o <= next_blink;
    end
  end
endmodule

//--- rtl/lpc_regs_top.sv
// How it works
// - Blink-rate bits 10-9 reset to 2 and pick 50/100/200/500 ms phases.
// - Link-LED polarity bit 7: low in common mode, strap otherwise, writable.
// - Force bit 4 drives the level bit onto the link LED pin.
// - Level bit 1 is the forced pin value, used only while forcing.
// - Auto crossover bit 15 resets to 1 in common mode, else strap.
// - Forced crossover bit 14 swaps pairs; strap loads it when auto strapped off outside common mode, else it resets to 0.
// - Bit 13 is pause-receive resolution, full duplex only.
// - Bit 12 is pause-transmit resolution, full duplex only.
// - Bit 11 reads 1 only with negotiated 100 full-duplex link.
// - Control bit 7 bypasses LED stretching, showing the raw value.
// - Address bits 4-0 load from the address straps at reset.
//
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`include "lpc_regs.svh"
module lpc_regs_top
  import lpc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        common_pinout_mode_i,
  input  wire logic        strap_led_pol_i,
  input  wire logic        strap_auto_x_i,
  input  wire logic        strap_force_x_i,
  input  wire logic [4:0]  strap_addr_i,
  input  wire logic [1:0]  local_ability_advert_i,
  input  wire logic [1:0]  partner_ability_i,
  input  wire logic        an_done_i,
  input  wire logic        an_full_duplex_i,
  input  wire logic        an_speed_100_i,
  input  wire logic        link_up_i,
  input  wire logic        link_raw_i,
  input  wire logic        link_stretched_i,
  input  wire logic        activity_i,
  output logic             link_led_pin_o,
  output logic             auto_pair_crossover_o,
  output logic             transmit_pair_swap_o,
  output logic             stretch_bypass_o,
  output logic [4:0]       mgmt_addr_o
);
  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [15:0] led_control;
  logic [15:0] next_led_control;
  logic [15:0] phy_control;
  logic [15:0] next_phy_control;
  logic [2:0]  status;
  logic [2:0]  next_status;
  logic        strap_load;
  logic [31:0] next_dat;
  logic        next_ack;
  logic        next_pin;
  logic        blink;
  logic        sel_led;
  logic        sel_phy;
  logic [15:0] wmask;
  logic        fd_ok;
  logic        rx_pause;
  logic        tx_pause;

  lpc_blinker u_blink (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .rate_i  (lpc_rate_t'(led_control[`LPC_LED_RATE_HI:`LPC_LED_RATE_LO])),
    .blink_o (blink)
  );

  // ------------------------------------------------------------
  // Register bus and straps
  // ------------------------------------------------------------
  // Strap levels are caught on the first clock after reset release, never under reset.
  always_comb begin
    sel_led = wb_adr_i == `LPC_ADDR_LED_CONTROL;
    sel_phy = wb_adr_i == `LPC_ADDR_PHY_CONTROL;
    wmask   = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    next_led_control = led_control;
    next_phy_control = phy_control;
    next_ack = wb_cyc_i && wb_stb_i && !wb_ack_o;
    next_dat = 32'h0000_0000;
    if (strap_load) begin
      next_led_control[`LPC_LED_POL_BIT] = common_pinout_mode_i ? 1'b0
                                                                : strap_led_pol_i;
      next_phy_control[`LPC_PHY_AUTOX_BIT] = common_pinout_mode_i ? 1'b1
                                                                  : strap_auto_x_i;
      next_phy_control[`LPC_PHY_FORCEX_BIT] = !common_pinout_mode_i && !strap_auto_x_i
                                              && strap_force_x_i;
      next_phy_control[4:0] = strap_addr_i;
    end else if (next_ack && wb_we_i) begin
      // Only writable bits change; the address field and reserved bits hold.
      if (sel_led) begin
        next_led_control = (led_control & ~(wmask & `LPC_LED_RW_MASK))
                         | (wb_dat_i[15:0] & wmask & `LPC_LED_RW_MASK);
      end
      if (sel_phy) begin
        next_phy_control = (phy_control & ~(wmask & `LPC_PHY_RW_MASK))
                         | (wb_dat_i[15:0] & wmask & `LPC_PHY_RW_MASK);
      end
    end
    if (next_ack && !wb_we_i) begin
      if (sel_led) begin
        next_dat = {16'h0000, led_control};
      end else if (sel_phy) begin
        next_dat = {16'h0000, phy_control[15:14], status, phy_control[10:0]};
      end
    end
  end

  // ------------------------------------------------------------
  // Negotiated status and LED pin
  // ------------------------------------------------------------
  // Bit 1 of each pair is asymmetric pause, bit 0 symmetric pause.
  always_comb begin
    fd_ok = an_done_i && an_full_duplex_i;
    rx_pause = fd_ok && ((local_ability_advert_i[0] && partner_ability_i[0])
             || (local_ability_advert_i == 2'h3 && partner_ability_i == 2'h2));
    tx_pause = fd_ok && ((local_ability_advert_i[0] && partner_ability_i[0])
             || (local_ability_advert_i == 2'h2 && partner_ability_i == 2'h3));
    next_status = {rx_pause, tx_pause,
                   fd_ok && an_speed_100_i && link_up_i};
    next_pin = phy_control[`LPC_PHY_BYPASS_BIT] ? link_raw_i : link_stretched_i;
    // Activity blinks the lit link LED at the chosen rate.
    next_pin = next_pin && !(activity_i && blink);
    next_pin = next_pin ~^ led_control[`LPC_LED_POL_BIT];
    if (led_control[`LPC_LED_FORCE_BIT]) begin
      next_pin = led_control[`LPC_LED_LEVEL_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      led_control           <= `LPC_LED_RESET;
      phy_control           <= `LPC_PHY_RESET;
      status                <= 3'h0;
      strap_load            <= 1'b1;
      wb_ack_o              <= 1'b0;
      wb_dat_o              <= 32'h0000_0000;
      link_led_pin_o        <= 1'b0;
      auto_pair_crossover_o <= 1'b1;
      transmit_pair_swap_o  <= 1'b0;
      stretch_bypass_o      <= 1'b0;
      mgmt_addr_o           <= 5'h00;
    end else begin
      led_control           <= next_led_control;
      phy_control           <= next_phy_control;
      status                <= next_status;
      strap_load            <= 1'b0;
      wb_ack_o              <= next_ack;
      wb_dat_o              <= next_dat;
      link_led_pin_o        <= next_pin;
      auto_pair_crossover_o <= next_phy_control[`LPC_PHY_AUTOX_BIT];
      transmit_pair_swap_o  <= next_phy_control[`LPC_PHY_FORCEX_BIT];
      stretch_bypass_o      <= next_phy_control[`LPC_PHY_BYPASS_BIT];
      mgmt_addr_o           <= next_phy_control[4:0];
    end
  end
endmodule

//--- sim/lpc_regs_checker.sv
`timescale 1ns/1ps
module lpc_regs_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [1:0]  local_ability_advert_i,
  input wire logic [1:0]  partner_ability_i,
  input wire logic        an_done_i,
  input wire logic        an_full_duplex_i,
  input wire logic        an_speed_100_i,
  input wire logic        link_up_i,
  input wire logic [4:0]  strap_addr_i,
  input wire logic        link_led_pin_o,
  input wire logic        auto_pair_crossover_o,
  input wire logic        stretch_bypass_o,
  input wire logic [4:0]  mgmt_addr_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  wire req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wled = req && wb_we_i && wb_adr_i == 10'h060 && wb_sel_i[0];
  wire wphy = req && wb_we_i && wb_adr_i == 10'h064 && wb_sel_i[1] && wb_sel_i[0];
  wire rphy = req && !wb_we_i && wb_adr_i == 10'h064;
  wire fd   = an_done_i && an_full_duplex_i;
  wire sym  = local_ability_advert_i[0] && partner_ability_i[0];
  wire prx  = fd && (sym || local_ability_advert_i == 2'h3 && partner_ability_i == 2'h2);
  wire ptx  = fd && (sym || local_ability_advert_i == 2'h2 && partner_ability_i == 2'h3);
  wire plk  = fd && an_speed_100_i && link_up_i;
  // Status is registered once, then read data once, hence two cycles back.
  property status_bit(int b, logic e);
    rphy |=> wb_dat_o[b] == $past(e, 2);
  endproperty
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ack_resp: assert property (req |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_pause_rx: assert property (status_bit(13, prx))
    else $error("pause receive status wrong");
  a_pause_tx: assert property (status_bit(12, ptx))
    else $error("pause transmit status wrong");
  a_link_status: assert property (status_bit(11, plk))
    else $error("link status wrong");
  a_led_force: assert property (
    wled && wb_dat_i[4] |-> ##3 link_led_pin_o == $past(wb_dat_i[1], 3))
    else $error("forced led level not driven");
  a_autox_copy: assert property (
    wphy |-> ##3 auto_pair_crossover_o == $past(wb_dat_i[15], 3))
    else $error("auto crossover output wrong");
  a_bypass_copy: assert property (
    wphy |-> ##3 stretch_bypass_o == $past(wb_dat_i[7], 3))
    else $error("stretch bypass output wrong");
  a_addr_strap: assert property (
    $fell(rst_i) |-> ##2 mgmt_addr_o == $past(strap_addr_i, 2))
    else $error("address not loaded from straps");
  c_force: cover property (wled && wb_dat_i[4]);
  c_pause: cover property (rphy ##1 wb_dat_o[12]);
  c_autox: cover property (wphy && wb_dat_i[15]);
endmodule
bind lpc_regs_top lpc_regs_checker i_lpc_regs_checker (.*);

//--- sim/lpc_regs_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module lpc_regs_top_tb;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [9:0] wb_adr_i = 10'h000;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
  logic [3:0] wb_sel_i = 4'hF;
  logic link_led_pin_o, auto_pair_crossover_o, transmit_pair_swap_o, stretch_bypass_o;
  logic common_pinout_mode_i = 1, strap_led_pol_i = 1, strap_auto_x_i = 0, strap_force_x_i = 1;
  logic [4:0] strap_addr_i = 5'h15, mgmt_addr_o;
  logic [1:0] local_ability_advert_i = 2'h0, partner_ability_i = 2'h0;
  logic an_done_i = 0, an_full_duplex_i = 0, an_speed_100_i = 0, link_up_i = 0;
  logic link_raw_i = 0, link_stretched_i = 0, activity_i = 0;
  int n_errors = 0, tests_run = 0;
  wire [2:0] outs = {auto_pair_crossover_o, transmit_pair_swap_o, stretch_bypass_o};
  always #10 clk_i = ~clk_i;
  lpc_regs_top i_lpc_regs_top (.*);
  // ----------------------------------------
  // Bus cycle and scenarios
  // ----------------------------------------
  task automatic wb(input logic w, input logic [9:0] a, input logic [15:0] d,
                    output logic [31:0] q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Straps are sampled only just after reset, so each mode needs a fresh reset.
  task automatic t_reset(input logic m, p, ax, fx, input logic [4:0] ad);
    logic [31:0] q;
    common_pinout_mode_i <= m;
    strap_led_pol_i <= p;
    strap_auto_x_i <= ax;
    strap_force_x_i <= fx;
    strap_addr_i <= ad;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    wb(0, 10'h060, 16'h0000, q);
    `CHK("led reset", 32'h0000_0400 | {24'h0, p & !m, 7'h0}, q)
    wb(0, 10'h064, 16'h0000, q);
    `CHK("phy reset", {16'h0, m | ax, !m & !ax & fx, 9'h0, ad}, q)
    `CHK("straps", {25'h0, m | ax, !m & !ax & fx, ad}, {25'h0, outs[2:1], mgmt_addr_o})
    $display("reset test done");
  endtask
  task automatic t_rw();
    logic [31:0] q;
    logic [15:0] v;
    for (int i = 0; i < 2; i++) begin
      v = i ? 16'h0000 : 16'hFFFF;
      wb(1, 10'h060, v, q);
      wb(1, 10'h064, v, q);
      wb(0, 10'h060, 16'h0000, q);
      `CHK("led rw", {16'h0, v & 16'h0692}, q)
      wb(0, 10'h064, 16'h0000, q);
      `CHK("phy rw", {16'h0, v & 16'hC0A0 | 16'h0015}, q)
      `CHK("phy outs", {29'h0, v[15], v[14], v[7]}, {29'h0, outs})
    end
    $display("rw test done");
  endtask
  task automatic pin_case(input logic [15:0] p, l, input logic e);
    logic [31:0] q;
    wb(1, 10'h064, p, q);
    wb(1, 10'h060, l, q);
    repeat (3) @(posedge clk_i);
    `CHK("pin", {31'h0, e}, {31'h0, link_led_pin_o})
  endtask
  task automatic t_status();
    logic [31:0] q;
    logic f, rx, tx;
    logic [1:0] l, p;
    for (int k = 0; k < 17; k++) begin
      f = k < 16;
      l = k[3:2];
      p = k[1:0];
      rx = f && (l[0] && p[0] || l == 2'h3 && p == 2'h2);
      tx = f && (l[0] && p[0] || l == 2'h2 && p == 2'h3);
      local_ability_advert_i <= l;
      partner_ability_i <= p;
      {an_done_i, an_full_duplex_i, an_speed_100_i, link_up_i} <= {1'b1, f, 2'h3};
      wb(0, 10'h064, 16'h0000, q);
      `CHK("pause rx", {31'h0, rx}, {31'h0, q[13]})
      `CHK("pause tx", {31'h0, tx}, {31'h0, q[12]})
      `CHK("link", {31'h0, f}, {31'h0, q[11]})
    end
    wb(1, 10'h068, 16'hFFFF, q);
    wb(0, 10'h068, 16'h0000, q);
    `CHK("unmapped", 32'h0000_0000, q)
    $display("status test done");
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    t_reset(1'b1, 1'b1, 1'b0, 1'b1, 5'h15);
    t_rw();
    link_raw_i <= 1'b1;
    pin_case(16'h0080, 16'h0012, 1'b1);
    pin_case(16'h0080, 16'h0010, 1'b0);
    pin_case(16'h0080, 16'h0080, 1'b1);
    pin_case(16'h0080, 16'h0002, 1'b0);
    pin_case(16'h0000, 16'h0080, 1'b0);
    $display("pin test done");
    t_status();
    t_reset(1'b0, 1'b1, 1'b0, 1'b1, 5'h0A);
    t_reset(1'b0, 1'b0, 1'b1, 1'b1, 5'h11);
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    final_report();
  end
endmodule
